// ==== hw/field_cell_regs.vh ====
// Attribute codes, code width and write-only read level for the register field cell bank.
// Assumes an embedding register port that supplies read/write strobes.
// Overview of operation
// - Read-only field returns its value and ignores every write.
// - Write-only field stores writes; read data is unspecified.
// - Write-one-to-clear clears bits written one, keeps bits written zero.
// - Any write to an any-write-clears field clears it.
// - Read-to-clear returns contents then clears; writes do nothing.
// - Latch-low and latch-high fields hold until the register is read.
// - Self-clearing field returns to zero after its action; zero writes ignored.
// - Self-setting field returns to one by itself; one writes ignored.
// - Read-only latch-high goes high on condition, after read follows condition.
// - Unread latched-high bit stays high though the condition goes away.
// - Soft-reset-immune fields keep value on software reset; hardware reset only.
// - Combined attributes apply together, e.g. read-write with any-write-clears; the RW+WAC cell clears on any write and never stores write data.
`ifndef FIELD_CELL_REGS_VH
`define FIELD_CELL_REGS_VH
`define ATTR_RW 4'h0
`define ATTR_RO 4'h1
`define ATTR_WO 4'h2
`define ATTR_W1C 4'h3
`define ATTR_WAC 4'h4
`define ATTR_RC 4'h5
`define ATTR_LL 4'h6
`define ATTR_LH 4'h7
`define ATTR_SC 4'h8
`define ATTR_SS 4'h9
`define ATTR_RWWAC 4'ha
`define ATTR_RSVD 4'hf
`define ATTR_W 4
`define WO_READ_VALUE 1'b0
`endif

// ==== hw/field_cells.v ====
// Bank of one-bit register field cells, each with a per-bit access attribute.
// Assumes the embedding register port gives one-cycle read and write strobes.
`include "field_cell_regs.vh"

module field_cells #(
  parameter WIDTH = 16,
  parameter [WIDTH*`ATTR_W-1:0] ATTRS = {WIDTH{`ATTR_RW}},
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}},
  parameter [WIDTH-1:0] SOFT_IMMUNE = {WIDTH{1'b0}}
) (
  input wire mclk,
  input wire nrst,
  input wire soft_rst,
  input wire rd_stb,
  input wire wr_stb,
  input wire [WIDTH-1:0] wr_data,
  input wire [WIDTH-1:0] hw_cond,
  input wire [WIDTH-1:0] hw_done,
  output wire [WIDTH-1:0] rd_data,
  output wire [WIDTH-1:0] field_value
);

  // Bank-wide access qualifiers, one bit per cell
  // Gating data with the strobe once keeps stale data out of every cell
  wire [WIDTH-1:0] wr_one;
  wire [WIDTH-1:0] wr_zero;
  wire [WIDTH-1:0] wr_any;
  wire [WIDTH-1:0] rd_any;
  wire [WIDTH-1:0] soft_hit;
  wire [WIDTH-1:0] hard_hit;

  // Write of a one or a zero, valid only while the strobe is high
  assign wr_one = {WIDTH{wr_stb}} & wr_data;
  assign wr_zero = {WIDTH{wr_stb}} & ~wr_data;

  // Access seen by every cell of the register, whatever the data
  assign wr_any = {WIDTH{wr_stb}};
  assign rd_any = {WIDTH{rd_stb}};

  // immune bits skip soft reset
  // Immunity is fixed per bit, so no write can strip it at run time
  assign soft_hit = {WIDTH{soft_rst}} & ~SOFT_IMMUNE;

  // Hardware reset reaches every cell, immune or not
  assign hard_hit = {WIDTH{~nrst}};

  genvar i;

  // One cell per bit; attribute chosen at elaboration
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_cell
      localparam [`ATTR_W-1:0] A = ATTRS[i*`ATTR_W +: `ATTR_W];

      // Which inputs this attribute listens to
      // Unused inputs are tied off so a stray pulse cannot disturb the cell
      localparam [0:0] USES_COND = (A == `ATTR_RO) || (A == `ATTR_W1C) || (A == `ATTR_WAC) ||
                                   (A == `ATTR_RC) || (A == `ATTR_LL) || (A == `ATTR_LH);
      localparam [0:0] USES_DONE = (A == `ATTR_SC) || (A == `ATTR_SS);
      localparam [0:0] TAKES_WRITE = (A == `ATTR_RW) || (A == `ATTR_WO) || (A == `ATTR_W1C) ||
                                     (A == `ATTR_WAC) || (A == `ATTR_SC) || (A == `ATTR_SS) ||
                                     (A == `ATTR_RWWAC);
      localparam [0:0] READ_CLEARS = (A == `ATTR_RC) || (A == `ATTR_LL) || (A == `ATTR_LH);

      // Stored bit, its next value and the bit as seen on a read
      reg value;
      reg next_value;
      reg read_bit;

      // Inputs after the attribute's own mask
      wire cond_in;
      wire done_in;
      wire rd_in;
      wire wr1_in;
      wire wr0_in;
      wire wrany_in;

      // Candidate next values, one per attribute; only one is used
      wire nv_rw;
      wire nv_ro;
      wire nv_wo;
      wire nv_w1c;
      wire nv_wac;
      wire nv_rc;
      wire nv_ll;
      wire nv_lh;
      wire nv_sc;
      wire nv_ss;
      wire nv_rwwac;
      wire nv_rsvd;

      // Unused inputs read as idle; refused writes stop here
      assign cond_in = hw_cond[i] & USES_COND;
      assign done_in = hw_done[i] & USES_DONE;
      assign rd_in = rd_any[i] & READ_CLEARS;
      assign wr1_in = wr_one[i] & TAKES_WRITE;
      assign wr0_in = wr_zero[i] & TAKES_WRITE;
      assign wrany_in = wr_any[i] & TAKES_WRITE;

      // Plain read-write store
      assign nv_rw = wrany_in ? wr_data[i] : value;

      // writes ignored
      // Tracks the condition one cycle late; there is no write path
      assign nv_ro = cond_in;

      // plain store
      // Read data is masked later, so the stored value appears only on field_value
      assign nv_wo = wrany_in ? wr_data[i] : value;

      // one clears bit
      // Set wins over a clear in the same cycle, so no event is lost
      assign nv_w1c = cond_in | (value & ~wr1_in);

      assign nv_wac = cond_in | (value & ~wrany_in);

      // clear after read
      // Writes take no part; an event in the read cycle survives the read
      assign nv_rc = cond_in | (value & ~rd_in);

      // latch low held
      // Stored inverted: one means the low level was seen
      assign nv_ll = ~cond_in | (value & ~rd_in);

      // latch high held
      // After a read the bit follows the condition that still holds
      assign nv_lh = cond_in | (value & ~rd_in);

      // self clears when done
      // A write of one wins over done, so a restart is never dropped
      assign nv_sc = wr1_in ? 1'b1 : (done_in ? 1'b0 : value);

      // self sets when done
      // A write of zero wins over done for the same reason
      assign nv_ss = wr0_in ? 1'b0 : (done_in ? 1'b1 : value);

      // read-write plus any-write-clears
      // No hardware set; only the reset value can make it one
      assign nv_rwwac = wrany_in ? 1'b0 : value;

      assign nv_rsvd = 1'b0;

      // Pick the candidate for this cell's attribute
      // Exactly one branch survives elaboration per cell
      always @* begin
        next_value = value;
        case (A)
          // Holds between writes
          `ATTR_RW: begin
            next_value = nv_rw;
          end
          // Follows the condition
          `ATTR_RO: begin
            next_value = nv_ro;
          end
          // Holds between writes
          `ATTR_WO: begin
            next_value = nv_wo;
          end
          // Event set, one clears
          `ATTR_W1C: begin
            next_value = nv_w1c;
          end
          // Event set, any write clears
          `ATTR_WAC: begin
            next_value = nv_wac;
          end
          // Event set, read clears
          `ATTR_RC: begin
            next_value = nv_rc;
          end
          // Low level latched
          `ATTR_LL: begin
            next_value = nv_ll;
          end
          // High level latched
          `ATTR_LH: begin
            next_value = nv_lh;
          end
          // Set by write, cleared by done
          `ATTR_SC: begin
            next_value = nv_sc;
          end
          // Cleared by write, set by done
          `ATTR_SS: begin
            next_value = nv_ss;
          end
          // Cleared by any write
          `ATTR_RWWAC: begin
            next_value = nv_rwwac;
          end
          // Never stores anything
          `ATTR_RSVD: begin
            next_value = nv_rsvd;
          end
          // Unknown codes hold their value
          default: begin
            next_value = value;
          end
        endcase
      end

      // immune bits skip soft reset
      // Sync reset; hardware reset first, then the per-bit soft reset
      always @(posedge mclk) begin
        if (hard_hit[i]) begin
          value <= RESET_VALUE[i];
        end else if (soft_hit[i]) begin
          value <= RESET_VALUE[i];
        end else begin
          value <= next_value;
        end
      end

      // read masking; latch polarity for low latches
      // A low latch reads zero while latched, matching the pin level seen
      always @* begin
        read_bit = value;
        case (A)
          // Stored value as written
          `ATTR_RW: begin
            read_bit = value;
          end
          // Registered condition
          `ATTR_RO: begin
            read_bit = value;
          end
          // Write-only reads a fixed level
          `ATTR_WO: begin
            read_bit = `WO_READ_VALUE;
          end
          // Pending event
          `ATTR_W1C: begin
            read_bit = value;
          end
          // Pending event
          `ATTR_WAC: begin
            read_bit = value;
          end
          // Event before the read clears it
          `ATTR_RC: begin
            read_bit = value;
          end
          // Stored inverted
          `ATTR_LL: begin
            read_bit = ~value;
          end
          // Latched high level
          `ATTR_LH: begin
            read_bit = value;
          end
          // Action still running
          `ATTR_SC: begin
            read_bit = value;
          end
          // Action still running while low
          `ATTR_SS: begin
            read_bit = value;
          end
          // Current setting
          `ATTR_RWWAC: begin
            read_bit = value;
          end
          // Reserved reads zero
          `ATTR_RSVD: begin
            read_bit = 1'b0;
          end
          default: begin
            read_bit = value;
          end
        endcase
      end

      // Read data straight from the flop, no extra latency
      assign rd_data[i] = read_bit;
      assign field_value[i] = value;
    end
  endgenerate

endmodule // field_cells

// ==== dv/field_cells_properties.sv ====
// Checks on the bench's bank: 0 RO,1 W1C,2 ANY_WRITE_CLEARS,3 RC,4 LH,5 SC,6 SS,7 rsvd,
// 8 RW+ANY_WRITE_CLEARS, 9 LL stored inverted. Bound to every field_cells instance.
module field_cells_chk #(parameter WIDTH = 12) (input wire mclk, nrst, soft_rst, rd_stb, wr_stb,
  input wire [WIDTH-1:0] wr_data, hw_cond, hw_done, rd_data, field_value);
  wire [WIDTH-1:0] v = field_value, c = hw_cond;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  ro_lag_a: assert property ($past(nrst) && !$past(soft_rst) |-> v[0] == $past(c[0])) else $error("ro");
  w1c_clr_a: assert property (wr_stb && wr_data[1] && !c[1] |=> !v[1]) else $error("wc");
  w1c_keep_a: assert property (wr_stb && !wr_data[1] && v[1] |=> v[1]) else $error("wk");
  wac_clr_a: assert property (wr_stb && !c[2] |=> !v[2]) else $error("wa");
  rc_clr_a: assert property (rd_stb && !c[3] |=> !v[3]) else $error("rc");
  lh_hold_a: assert property (v[4] && !rd_stb && !soft_rst |=> v[4]) else $error("lh");
  sc_clr_a: assert property (hw_done[5] && !wr_stb |=> !v[5]) else $error("sc");
  rsvd_zero_a: assert property (rd_data[7] == 0) else $error("rz");
  rwwac_clr_a: assert property (wr_stb && !soft_rst |=> !v[8]) else $error("rw");
  ll_hold_a: assert property (v[9] && !rd_stb && !soft_rst |=> v[9]) else $error("ll");
  cover property (rd_stb && v[9]);
  cover property (rd_stb && v[4]);
  cover property (wr_stb && v[1]);
  cover property (soft_rst && v[1]);
endmodule // field_cells_chk
bind field_cells field_cells_chk #(.WIDTH(WIDTH)) chk (.*);

// ==== dv/register_field_attribute_cells_tb_top.sv ====
// Field bank bench, twelve mixed cells.
// Needs field_cells and its checker.
module register_field_attribute_cells_tb_top;
  timeunit 1ns; timeprecision 1ps;
  reg mclk = 0, nrst = 0, soft_rst = 0, rd_stb = 0, wr_stb = 0;
  // Condition bit 9 idles high: the latch-low cell watches for it to drop
  reg [11:0] wr_data = 12'h000, hw_cond = 12'h200, hw_done = 12'h000;
  wire [11:0] rd_data;
  wire [11:0] field_value;
  int num_errors = 0, cmp_count = 0;
  // Bits 11..0: RW, WO, LL, RW+ANY_WRITE_CLEARS, rsvd, SS, SC, LH, RC, ANY_WRITE_CLEARS, W1C, RO
  field_cells #(.WIDTH(12), .ATTRS(48'h026af9875431), .RESET_VALUE(12'h100),
    .SOFT_IMMUNE(12'h002)) uut (.*);
  always #2.5 mclk = ~mclk;
  task cyc; @(posedge mclk); #1; endtask
  task hc(input [11:0] c); hw_cond = c; cyc; hw_cond = 12'h200; endtask
  task wr(input [11:0] d); wr_data = d; wr_stb = 1; cyc; wr_stb = 0; cyc; endtask
  task chk(input [11:0] e); cmp_count++;
    if (rd_data !== e) begin num_errors++; $display("Error %0t %h %h", $time, rd_data, e); end
  endtask
  task chk_fv(input [11:0] e); cmp_count++;
    if (field_value !== e) begin
      num_errors++; $display("Error %0t %h %h", $time, field_value, e);
    end
  endtask
  task t_wr; hc(12'h20e); chk(12'h30e);
    wr(12'h004); chk(12'h20a);
    chk_fv(12'h00a);
    wr(12'h002); chk(12'h208);
    wr(12'hc7f);
    chk(12'ha28);
    chk_fv(12'hc28);
    rd_stb = 1; #1 chk(12'ha28);
    cyc; rd_stb = 0; chk(12'ha20);
    hw_done = 12'h060; cyc; hw_done = 12'h000; chk(12'ha40);
    chk_fv(12'hc40);
  endtask
  task t_lh; hc(12'h211); chk(12'ha51);
    cyc; chk(12'ha50);
    rd_stb = 1; cyc; rd_stb = 0; chk(12'ha40);
    hc(12'h000); chk(12'h840);
    cyc; chk(12'h840);
    rd_stb = 1; cyc; rd_stb = 0; chk(12'ha40);
    wr(12'h001); chk(12'h200);
    hc(12'h20a); soft_rst = 1; cyc; soft_rst = 0; chk(12'h302);
    chk_fv(12'h102);
  endtask
  task results;
    $display("%0d errors, %0d checks", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (5) cyc;
    nrst = 1; t_wr; t_lh; results;
  end
endmodule // register_field_attribute_cells_tb_top
